/* hw/clk_ctrl_defines.vh */
// Register map, field positions, reset values and timing counts of the clock and power mode controller
`ifndef CLK_CTRL_DEFINES_VH
`define CLK_CTRL_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_SYS_CLOCK_CONTROL 6'h00
`define OFS_FAST_OSC_CONTROL 6'h01
`define OFS_POWER_STATUS 6'h02
`define OFS_INT_STATUS 6'h03
`define OFS_INT_MASK 6'h04

// ****************************************
// Field positions
// ****************************************
`define SCC_CKS_HI 7
`define SCC_CKS_LO 5
`define SCC_FAST_IDLE 1
`define SCC_SLOW_IDLE 0
`define FOC_STABLE 1
`define FOC_ENABLE 0
`define PST_PDF 0
`define PST_TO 1
`define PST_MODE_LO 2
`define PST_SLOW_STABLE 5
`define PST_SRC_LO 6
`define EV_FAST_STABLE 0
`define EV_SWITCH_DONE 1
`define EV_POWER_DOWN 2
`define EV_WDT_TIMEOUT 3

// ****************************************
// Reset values and codes
// ****************************************
`define RST_CKS 3'h0
`define RST_FAST_IDLE 1'b0
`define RST_SLOW_IDLE 1'b0
`define RST_FAST_EN 1'b1
`define CKS_SUB 3'h7

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 40
`define FAST_STABLE_NS 16000
`define SLOW_STABLE_NS 100000
`define SUB_PERIOD_NS 31250
`define FAST_STABLE_CYC 12'h190
`define SLOW_STABLE_CYC 12'h9C4
`define SUB_DIV_CYC 10'h30D

`endif

/* hw/system_clock_power_mode_ctrl.v */
// System clock source selection, oscillator control and power-down mode entry
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "clk_ctrl_defines.vh"

// Behaviour
// - clock_select 000..110 gives fast clock divided 1..64; 111 gives sub clock
// - fast_osc_idle_enable set keeps fast oscillator running while halted
// - slow_osc_idle_enable set keeps slow oscillator running while halted
// - writing fast_osc_enable one clears stable flag, sets it once stable
// - fast_osc_enable switches the fast oscillator in run only while sub clock is selected and in use; resets to one
// - upper six bits of fast_osc_control read zero
// - switch to sub clock completes only once slow oscillator is stable
// - back to fast clock waits for restart; stable flag shows progress
// - halt with both idle bits zero enters sleep, system clock stops
// - halt with fast zero, slow one enters idle_slow_only
// - halt with both idle bits one enters idle_both
// - any power-down stops program, keeps memory, registers and ports
// - power-down entry sets power_down_flag, clears watchdog_timeout_flag unless a timeout arrives in the same cycle
// - power-down entry clears watchdog; it resumes only if enabled
// - halt with fast one, slow zero enters idle_fast_only
// - sub clock from slow oscillator, fast clock from fast oscillator
module system_clock_power_mode_ctrl (
  input wire clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire haltReq,
  input wire wakeReq,
  input wire clrWdtReq,
  input wire wdtEnable,
  input wire wdtTimeout,
  output reg cpuRun_ff,
  output reg sysClkEn_ff,
  output reg fastClkEn_ff,
  output reg subClkEn_ff,
  output reg fastOscOn_ff,
  output reg slowOscOn_ff,
  output reg wdtClear_ff,
  output reg wdtRun_ff,
  output reg [2:0] opMode_ff,
  output reg irq_ff
);

  localparam ST_RUN = 3'h0;
  localparam ST_SLEEP = 3'h1;
  localparam ST_IDLE_SLOW = 3'h2;
  localparam ST_IDLE_BOTH = 3'h3;
  localparam ST_IDLE_FAST = 3'h4;
  localparam [11:0] FAST_STAB = `FAST_STABLE_CYC;
  localparam [11:0] SLOW_STAB = `SLOW_STABLE_CYC;
  localparam [9:0] SUB_DIV = `SUB_DIV_CYC;

  reg [2:0] cks_ff;
  reg fastIdleEn_ff;
  reg slowIdleEn_ff;
  reg fastOscEn_ff;
  reg fastStable_ff;
  reg slowStable_ff;
  reg [11:0] fastStabCnt_ff;
  reg [11:0] slowStabCnt_ff;
  reg pdf_ff;
  reg toFlag_ff;
  reg [3:0] intStat_ff;
  reg [3:0] intMask_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [2:0] srcSel_ff;
  reg [5:0] divCnt_ff;
  reg [9:0] subCnt_ff;
  reg wrPend_ff;
  reg [5:0] wrIdx_ff;
  reg [31:0] rdMux;
  reg [3:0] events;
  reg wantFast;
  reg wantSlow;
  reg sysOn;
  reg nxt_sysOn;
  wire addrPhase;
  wire wrScc;
  wire wrFoc;
  wire fastRestart;
  wire fastTick;
  wire subTick;
  wire [5:0] divMask;
  wire divTick;
  wire curTick;
  wire tgtReady;
  wire doSwitch;
  wire enterPd;

  // ****************************************
  // Bus slave
  // ****************************************
  assign addrPhase = hsel & htrans[1] & hready;
  assign wrScc = wrPend_ff & (wrIdx_ff == `OFS_SYS_CLOCK_CONTROL);
  assign wrFoc = wrPend_ff & (wrIdx_ff == `OFS_FAST_OSC_CONTROL);

  always @*
  begin
    case (haddr[7:2])
      `OFS_SYS_CLOCK_CONTROL: rdMux = {24'h000000, cks_ff, 3'h0, fastIdleEn_ff, slowIdleEn_ff};
      `OFS_FAST_OSC_CONTROL: rdMux = {30'h00000000, fastStable_ff, fastOscEn_ff};
      `OFS_POWER_STATUS: rdMux = {23'h000000, srcSel_ff, slowStable_ff, state_ff, toFlag_ff, pdf_ff};
      `OFS_INT_STATUS: rdMux = {28'h0000000, intStat_ff};
      `OFS_INT_MASK: rdMux = {28'h0000000, intMask_ff};
      default: rdMux = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPend_ff <= 1'b0;
      wrIdx_ff <= 6'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend_ff <= addrPhase & hwrite;
      if (addrPhase)
        wrIdx_ff <= haddr[7:2];
      if (addrPhase & ~hwrite)
        hrdata <= rdMux;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cks_ff <= `RST_CKS;
      fastIdleEn_ff <= `RST_FAST_IDLE;
      slowIdleEn_ff <= `RST_SLOW_IDLE;
      fastOscEn_ff <= `RST_FAST_EN;
      intMask_ff <= 4'h0;
    end
    else
    begin
      if (wrScc)
      begin
        cks_ff <= hwdata[`SCC_CKS_HI:`SCC_CKS_LO];
        fastIdleEn_ff <= hwdata[`SCC_FAST_IDLE];
        slowIdleEn_ff <= hwdata[`SCC_SLOW_IDLE];
      end
      if (wrFoc)
        fastOscEn_ff <= hwdata[`FOC_ENABLE];
      if (wrPend_ff & (wrIdx_ff == `OFS_INT_MASK))
        intMask_ff <= hwdata[3:0];
    end
  end

  // ****************************************
  // Oscillator control
  // ****************************************
  always @*
  begin
    if (state_ff == ST_RUN)
    begin
      // enable bit, kept on while selected
      wantFast = fastOscEn_ff | (cks_ff != `CKS_SUB) | (srcSel_ff != `CKS_SUB);
      wantSlow = 1'b1;
    end
    else
    begin
      wantFast = fastIdleEn_ff;
      wantSlow = slowIdleEn_ff | wdtEnable;
    end
  end

  assign fastRestart = wrFoc & hwdata[`FOC_ENABLE];

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fastOscOn_ff <= 1'b1;
      slowOscOn_ff <= 1'b1;
      fastStable_ff <= 1'b0;
      fastStabCnt_ff <= 12'h000;
      slowStable_ff <= 1'b0;
      slowStabCnt_ff <= 12'h000;
    end
    else
    begin
      fastOscOn_ff <= wantFast;
      slowOscOn_ff <= wantSlow;
      if (!fastOscOn_ff | fastRestart)
      begin
        fastStable_ff <= 1'b0;
        fastStabCnt_ff <= 12'h000;
      end
      else if (fastStabCnt_ff == FAST_STAB - 12'h001)
      begin
        fastStable_ff <= 1'b1;
      end
      else
      begin
        fastStabCnt_ff <= fastStabCnt_ff + 12'h001;
      end
      if (!slowOscOn_ff)
      begin
        slowStable_ff <= 1'b0;
        slowStabCnt_ff <= 12'h000;
      end
      else if (slowStabCnt_ff == SLOW_STAB - 12'h001)
      begin
        slowStable_ff <= 1'b1;
      end
      else
      begin
        slowStabCnt_ff <= slowStabCnt_ff + 12'h001;
      end
    end
  end

  // ****************************************
  // Clock dividers and source switch
  // ****************************************
  // clocks from the two oscillators
  assign fastTick = fastOscOn_ff & fastStable_ff;
  assign subTick = slowOscOn_ff & slowStable_ff & (subCnt_ff == SUB_DIV - 10'h001);
  assign divMask = (srcSel_ff == `CKS_SUB) ? 6'h00 : ((6'h01 << srcSel_ff) - 6'h01);
  assign divTick = fastTick & ((divCnt_ff & divMask) == divMask);
  assign curTick = (srcSel_ff == `CKS_SUB) ? subTick : divTick;
  // sub clock needs slow stable; fast needs restart
  assign tgtReady = (cks_ff == `CKS_SUB) ? slowStable_ff : fastStable_ff;
  // switch at end of a full period, or at once if the current source is not stable
  assign doSwitch = (cks_ff != srcSel_ff) & tgtReady & (curTick | ((srcSel_ff == `CKS_SUB) ? ~slowStable_ff : ~fastStable_ff));

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      srcSel_ff <= `RST_CKS;
      divCnt_ff <= 6'h00;
      subCnt_ff <= 10'h000;
    end
    else
    begin
      if (slowOscOn_ff & slowStable_ff)
      begin
        subCnt_ff <= subTick ? 10'h000 : subCnt_ff + 10'h001;
      end
      if (doSwitch)
      begin
        srcSel_ff <= cks_ff;
        divCnt_ff <= 6'h00;
      end
      else if (fastTick)
      begin
        divCnt_ff <= divCnt_ff + 6'h01;
      end
    end
  end

  // ****************************************
  // Power mode state machine
  // ****************************************
  assign enterPd = (state_ff == ST_RUN) & haltReq;

  always @*
  begin
    case (state_ff)
      ST_RUN:
      begin
        nxt_state = ST_RUN;
        if (haltReq)
        begin
          case ({fastIdleEn_ff, slowIdleEn_ff})
            2'b00: nxt_state = ST_SLEEP;
            2'b01: nxt_state = ST_IDLE_SLOW;
            2'b10: nxt_state = ST_IDLE_FAST;
            default: nxt_state = ST_IDLE_BOTH;
          endcase
        end
      end
      ST_SLEEP, ST_IDLE_SLOW, ST_IDLE_BOTH, ST_IDLE_FAST: nxt_state = wakeReq ? ST_RUN : state_ff;
      default: nxt_state = ST_RUN;
    endcase
  end

  always @*
  begin
    case (state_ff)
      ST_RUN: sysOn = 1'b1;
      ST_IDLE_SLOW: sysOn = (srcSel_ff == `CKS_SUB);
      ST_IDLE_FAST: sysOn = (srcSel_ff != `CKS_SUB);
      ST_IDLE_BOTH: sysOn = 1'b1;
      default: sysOn = 1'b0;
    endcase
    nxt_sysOn = sysOn;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_RUN;
      opMode_ff <= ST_RUN;
      cpuRun_ff <= 1'b1;
      sysClkEn_ff <= 1'b0;
      fastClkEn_ff <= 1'b0;
      subClkEn_ff <= 1'b0;
      wdtClear_ff <= 1'b0;
      wdtRun_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      opMode_ff <= nxt_state;
      // core held at halt, state kept
      cpuRun_ff <= (nxt_state == ST_RUN);
      sysClkEn_ff <= curTick & nxt_sysOn;
      // fast clock stops with its oscillator
      fastClkEn_ff <= fastTick & wantFast;
      subClkEn_ff <= subTick & (state_ff != ST_SLEEP) & (state_ff != ST_IDLE_FAST);
      wdtClear_ff <= enterPd;
      wdtRun_ff <= wdtEnable & slowOscOn_ff & slowStable_ff & ~enterPd;
    end
  end

  // ****************************************
  // Status flags and interrupt
  // ****************************************
  always @*
  begin
    events = 4'h0;
    events[`EV_FAST_STABLE] = fastOscOn_ff & ~fastRestart & ~fastStable_ff & (fastStabCnt_ff == FAST_STAB - 12'h001);
    events[`EV_SWITCH_DONE] = doSwitch;
    events[`EV_POWER_DOWN] = enterPd;
    events[`EV_WDT_TIMEOUT] = wdtTimeout;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pdf_ff <= 1'b0;
      toFlag_ff <= 1'b0;
      intStat_ff <= 4'h0;
      irq_ff <= 1'b0;
    end
    else
    begin
      // power down flag set on entry
      if (enterPd)
        pdf_ff <= 1'b1;
      else if (clrWdtReq)
        pdf_ff <= 1'b0;
      if (wdtTimeout)
        toFlag_ff <= 1'b1;
      else if (enterPd)
        toFlag_ff <= 1'b0;
      if (wrPend_ff & (wrIdx_ff == `OFS_INT_STATUS))
        intStat_ff <= (intStat_ff & ~hwdata[3:0]) | events;
      else
        intStat_ff <= intStat_ff | events;
      irq_ff <= |(intStat_ff & intMask_ff);
    end
  end

endmodule

/* verification/clk_ctrl_props.sv */
// Port assertions for the clock and power mode controller
`timescale 1ns/100ps
module clk_ctrl_props (
  input wire clk,
  input wire rst_n,
  input wire haltReq,
  input wire wakeReq,
  input wire cpuRun_ff,
  input wire sysClkEn_ff,
  input wire fastClkEn_ff,
  input wire subClkEn_ff,
  input wire fastOscOn_ff,
  input wire slowOscOn_ff,
  input wire wdtClear_ff,
  input wire wdtRun_ff,
  input wire [2:0] opMode_ff
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire isRun = opMode_ff == 3'h0;
  chk_halt_enters: assert property (isRun && haltReq |=> !isRun && !cpuRun_ff)
    else $error("halt not taken");
  chk_halt_ignored: assert property (!isRun && haltReq && !wakeReq |=> $stable(opMode_ff))
    else $error("halt acted on while halted");
  chk_wake_resumes: assert property (!isRun && wakeReq |=> isRun && cpuRun_ff)
    else $error("wake not taken");
  chk_wdt_clear: assert property (isRun && haltReq |=> wdtClear_ff && !wdtRun_ff ##1 !wdtClear_ff)
    else $error("watchdog not cleared on halt");
  chk_sleep_stops: assert property (opMode_ff == 3'h1 [*2] |-> !sysClkEn_ff && !subClkEn_ff && !fastOscOn_ff)
    else $error("clock running in sleep");
  chk_idle_slow: assert property (opMode_ff == 3'h2 [*2] |-> !fastOscOn_ff && !fastClkEn_ff && slowOscOn_ff)
    else $error("wrong oscillators in slow idle");
  chk_idle_both: assert property (opMode_ff == 3'h3 [*2] |-> fastOscOn_ff && slowOscOn_ff)
    else $error("oscillator stopped in full idle");
  chk_idle_fast: assert property (opMode_ff == 3'h4 [*2] |-> fastOscOn_ff && !subClkEn_ff)
    else $error("wrong clocks in fast idle");
  chk_fast_source: assert property (fastClkEn_ff |-> fastOscOn_ff)
    else $error("fast clock without oscillator");
endmodule

bind system_clock_power_mode_ctrl clk_ctrl_props chk (
  .clk(clk),
  .rst_n(rst_n),
  .haltReq(haltReq),
  .wakeReq(wakeReq),
  .cpuRun_ff(cpuRun_ff),
  .sysClkEn_ff(sysClkEn_ff),
  .fastClkEn_ff(fastClkEn_ff),
  .subClkEn_ff(subClkEn_ff),
  .fastOscOn_ff(fastOscOn_ff),
  .slowOscOn_ff(slowOscOn_ff),
  .wdtClear_ff(wdtClear_ff),
  .wdtRun_ff(wdtRun_ff),
  .opMode_ff(opMode_ff)
);

/* verification/core_model.sv */
// Processor core model issuing halt, wake and watchdog instructions
`timescale 1ns/100ps
module core_model (
  input wire clk,
  output reg haltReq,
  output reg wakeReq,
  output reg clrWdtReq,
  output reg wdtTimeout
);
  initial
  begin
    {haltReq, wakeReq, clrWdtReq, wdtTimeout} = 4'h0;
  end
  task pulse(input [1:0] k);
  begin
    @(posedge clk);
    {haltReq, wakeReq, clrWdtReq, wdtTimeout} <= 4'h8 >> k;
    @(posedge clk);
    {haltReq, wakeReq, clrWdtReq, wdtTimeout} <= 4'h0;
  end
  endtask
endmodule

/* verification/test_system_clock_power_mode_ctrl.sv */
// Testbench for the clock and power mode controller
`timescale 1ns/100ps
module test_system_clock_power_mode_ctrl;
  logic clk, rst_n, hsel, hwrite, wdtEnable;
  logic [31:0] haddr, hwdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire [31:0] hrdata;
  wire hreadyout, hresp, haltReq, wakeReq, clrWdtReq, wdtTimeout, cpuRun_ff, sysClkEn_ff;
  wire fastClkEn_ff, subClkEn_ff, fastOscOn_ff, slowOscOn_ff, wdtClear_ff, wdtRun_ff, irq_ff;
  wire [2:0] opMode_ff;
  logic [2:0] modes [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
  int errors, checks, g, i;

  system_clock_power_mode_ctrl uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .haltReq(haltReq), .wakeReq(wakeReq), .clrWdtReq(clrWdtReq),
    .wdtEnable(wdtEnable), .wdtTimeout(wdtTimeout), .cpuRun_ff(cpuRun_ff), .sysClkEn_ff(sysClkEn_ff),
    .fastClkEn_ff(fastClkEn_ff), .subClkEn_ff(subClkEn_ff), .fastOscOn_ff(fastOscOn_ff),
    .slowOscOn_ff(slowOscOn_ff), .wdtClear_ff(wdtClear_ff), .wdtRun_ff(wdtRun_ff), .opMode_ff(opMode_ff),
    .irq_ff(irq_ff));
  core_model core (.clk(clk), .haltReq(haltReq), .wakeReq(wakeReq), .clrWdtReq(clrWdtReq),
    .wdtTimeout(wdtTimeout));

  always #20 clk = ~clk;

  task finish_test;
  begin
    $display("Counts: %0d checks, %0d errors", checks, errors);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask

  task check(input [31:0] seen, input [31:0] exp);
  begin
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask

  // Wait for hready at a rising edge
  task waitReady;
    int n;
  begin
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    check(n < 50, 1);
    if (n >= 50)
      finish_test;
  end
  endtask

  // One single word transfer
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] rv);
  begin
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    waitReady;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady;
    rv = hrdata;
    check(hresp, 32'h0);
  end
  endtask

  task poll(input [7:0] a, input [31:0] m, input [31:0] v);
    int k;
  begin
    xfer(1'b0, a, 32'h0, r);
    for (k = 0; k < 400 && (r & m) !== v; k++)
    begin
      repeat (20) @(posedge clk);
      xfer(1'b0, a, 32'h0, r);
    end
    check(r & m, v);
    if ((r & m) !== v)
      finish_test;
  end
  endtask

  // Cycles between two system clock pulses
  task gap;
    int k, n;
  begin
    n = 0;
    g = 0;
    for (k = 0; k < 4000 && n < 2; k++)
    begin
      @(posedge clk);
      if (n > 0)
        g++;
      if (sysClkEn_ff === 1'b1)
        n++;
    end
    if (n < 2)
      check(n, 2);
    if (n < 2)
      finish_test;
  end
  endtask

  initial
  begin
    {clk, rst_n, hsel, hwrite, wdtEnable, errors, checks} = 0;
    {haddr, hwdata, htrans} = 0;
    hsize = 3'h2;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b0, 8'h00, 32'h0, r);
    check(r, 32'h0);
    xfer(1'b0, 8'h04, 32'h0, r);
    check(r, 32'h1);
    xfer(1'b0, 8'h20, 32'h0, r);
    check(r, 32'h0);
    poll(8'h04, 32'hFF, 32'h3);
    xfer(1'b1, 8'h04, 32'hFF, r);
    xfer(1'b0, 8'h04, 32'h0, r);
    check(r, 32'h1);
    poll(8'h04, 32'hFF, 32'h3);
    $display("Test oscillator done");
    for (i = 0; i < 7; i++)
    begin
      xfer(1'b1, 8'h00, i << 5, r);
      repeat (150) @(posedge clk);
      gap;
      check(g, 1 << i);
    end
    xfer(1'b1, 8'h00, 32'hE0, r);
    poll(8'h08, 32'h1C0, 32'h1C0);
    gap;
    check(g, 781);
    xfer(1'b1, 8'h04, 32'h0, r);
    xfer(1'b1, 8'h00, 32'h0, r);
    poll(8'h08, 32'h1C0, 32'h0);
    gap;
    check(g, 1);
    xfer(1'b1, 8'h04, 32'h1, r);
    poll(8'h04, 32'h3, 32'h3);
    xfer(1'b0, 8'h0C, 32'h0, r);
    check(r, 32'h3);
    $display("Test clock select done");
    xfer(1'b1, 8'h10, 32'h4, r);
    for (i = 0; i < 4; i++)
    begin
      wdtEnable <= i == 0;
      xfer(1'b1, 8'h00, i, r);
      core.pulse(2'h3);
      core.pulse(2'h0);
      @(negedge clk);
      check(opMode_ff, modes[i]);
      check(cpuRun_ff, 0);
      check(wdtClear_ff, 1);
      repeat (3) @(posedge clk);
      check(fastOscOn_ff, i / 2);
      check(slowOscOn_ff, i % 2 | i == 0);
      check(wdtRun_ff, i == 0);
      check(irq_ff, 1);
      xfer(1'b0, 8'h08, 32'h0, r);
      check(r & 32'h3, 32'h1);
      core.pulse(2'h0);
      core.pulse(2'h1);
      @(negedge clk);
      check(cpuRun_ff, 1);
      xfer(1'b1, 8'h0C, 32'h4, r);
      repeat (3) @(posedge clk);
      check(irq_ff, 0);
      xfer(1'b1, 8'h0C, 32'hC, r);
      core.pulse(2'h2);
      xfer(1'b0, 8'h08, 32'h0, r);
      check(r & 32'h3, 32'h0);
    end
    $display("Test power modes done");
    finish_test;
  end
endmodule
